// ### verilog/uart_host_params.svh
// Constants for the parallel host port and its serial engine
`ifndef UART_HOST_PARAMS_SVH
`define UART_HOST_PARAMS_SVH
`define REG_DATA 3'h0
`define REG_IER 3'h1
`define REG_ISR 3'h2
`define REG_LCR 3'h3
`define REG_MCR 3'h4
`define REG_LSR 3'h5
`define REG_DIV_LO 3'h6
`define REG_DIV_HI 3'h7
`define MCR_INT_EN 3
`define MCR_ALT_IF 6
`define IER_RX 0
`define IER_TX 1
`define LSR_DR 0
`define LSR_OE 1
`define LSR_THRE 5
`define LSR_TEMT 6
`define ISR_NONE 8'h01
`define ISR_TX 8'h02
`define ISR_RX 8'h04
`define CLK_HZ 40000000
`define OVERSAMPLE 16
`define MIN_BPS 1200
`define PAR_MAX_BPS 230400
`define SER_MAX_BPS 921600
`define FIFO_DEPTH 64
`define DIV_RESET 16'h0823
`define RX_MID 4'h7
`endif

// ### verilog/uart_host_pkg.sv
// Types shared by the parallel host port
package uart_host_pkg;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
  } host_ctrl_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// ### verilog/byte_fifo.sv
// First-in first-out byte store with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage has no reset; only pointers and count carry control state
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// ### verilog/uart_parallel_host_port.sv
// Parallel host register port with its serial engine and byte buffers
//
// Contract
// RULE1 - Three address lines pick the register
// RULE2 - Embedded processor locked out in parallel mode
// RULE3 - Eight-bit two-way data bus
// RULE4 - Strobe style: read strobe fetches, drives byte
// RULE5 - Strobe style: write strobe rising edge stores
// RULE6 - Direction style: read strobe ignored, direction line
// RULE7 - Host pulls chip select low per access
// RULE8 - Chip select high: ignore all, float bus
// RULE9 - Strobe style: interrupt high, floated until enabled
// RULE10 - Direction style: interrupt low, open drain
// RULE11 - Transmit ready low shows buffer space
// RULE12 - Receive ready low shows data waiting
// RULE13 - Standard interface: transmit idles high
// RULE14 - Remote transmitter idles receive line high
// RULE15 - Parallel mode rate 1200 to 230400
// RULE16 - Serial mode rate 1200 to 921600
// RULE17 - Each buffer holds 64 bytes in order
`timescale 1ns/1ps
`include "uart_host_params.svh"
module uart_parallel_host_port #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Parallel host bus
  input wire uart_host_pkg::host_ctrl_t host_ctrl,
  input wire logic bus_style,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  // Embedded processor access
  input wire logic serial_host_mode,
  input wire uart_host_pkg::cpu_req_t cpu_req,
  output logic cpu_grant,
  output logic [7:0] cpu_rdata,
  // Host status
  output logic int_out,
  output logic int_oe_n,
  output logic tx_space_ready_n,
  output logic rx_data_ready_n,
  // Serial line
  output logic tx_pin,
  input wire logic rx_pin
);
  import uart_host_pkg::*;

  localparam int OS = `OVERSAMPLE;
  localparam int PAR_MIN_DIV = (`CLK_HZ + OS * `PAR_MAX_BPS - 1) / (OS * `PAR_MAX_BPS);
  localparam int SER_MIN_DIV = (`CLK_HZ + OS * `SER_MAX_BPS - 1) / (OS * `SER_MAX_BPS);
  localparam int MAX_DIV = `CLK_HZ / (OS * `MIN_BPS);
  localparam logic [3:0] OS_LAST = 4'(OS - 1);

  logic rd_n_q, wr_n_q, cs_n_q;
  logic [7:0] wr_hold;
  logic [2:0] addr_hold;
  logic par_rd, par_wr, acc_rd, acc_wr;
  logic [2:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] rd_data;
  logic [1:0] ier;
  logic [7:0] lcr, modem_ctrl_reg;
  logic [15:0] divisor, eff_div, baud_cnt;
  logic tick, overrun, irq;
  logic tx_full, tx_empty, rx_empty, tx_out_valid, tx_out_ready, rx_in_ready, rx_push;
  logic [7:0] tx_out_data, rx_out_data, rx_shift, tx_shift;
  tx_state_t tx_state;
  rx_state_t rx_state;
  logic [3:0] tx_cnt, rx_cnt;
  logic [2:0] tx_bit, rx_bit;
  logic tx_line, rx_meta, rx_sync, rx_src;

  ////////////////////////////////////////////////////////////////////////
  // Host access decode; pins are already synchronous to clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else begin
      rd_n_q <= host_ctrl.rd_n;
      wr_n_q <= host_ctrl.wr_n;
      cs_n_q <= host_ctrl.cs_n;
    end
  end

  // Write data and address follow the bus while a write phase is open
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_hold <= 8'h00;
      addr_hold <= 3'h0;
    end else if (!host_ctrl.cs_n && !host_ctrl.wr_n) begin // RULE7
      wr_hold <= host_data_bus_in; // RULE3
      addr_hold <= host_ctrl.addr; // RULE1
    end
  end

  // Strobe style acts on strobe edges; direction style on chip select edges
  always_comb begin
    par_rd = 1'b0;
    par_wr = 1'b0;
    if (!serial_host_mode) begin
      if (bus_style) begin
        par_rd = !host_ctrl.cs_n && !host_ctrl.rd_n && rd_n_q; // RULE4 RULE8
        par_wr = !host_ctrl.cs_n && host_ctrl.wr_n && !wr_n_q; // RULE5 RULE8
      end else begin
        par_rd = !host_ctrl.cs_n && cs_n_q && host_ctrl.wr_n; // RULE6
        par_wr = host_ctrl.cs_n && !cs_n_q && !wr_n_q; // RULE6
      end
    end
  end

  // The processor only reaches the registers in serial host mode
  assign cpu_grant = serial_host_mode && cpu_req.sel; // RULE2
  assign acc_rd = par_rd || (cpu_grant && !cpu_req.wr);
  assign acc_wr = par_wr || (cpu_grant && cpu_req.wr);
  assign acc_addr = serial_host_mode ? cpu_req.addr : (par_rd ? host_ctrl.addr : addr_hold);
  assign acc_wdata = serial_host_mode ? cpu_req.wdata : wr_hold;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ier <= 2'h0;
      lcr <= 8'h00;
      modem_ctrl_reg <= 8'h00;
      divisor <= `DIV_RESET;
    end else if (acc_wr) begin
      unique case (acc_addr) // RULE1
        `REG_IER: ier <= acc_wdata[1:0];
        `REG_LCR: lcr <= acc_wdata;
        `REG_MCR: modem_ctrl_reg <= acc_wdata;
        `REG_DIV_LO: divisor[7:0] <= acc_wdata;
        `REG_DIV_HI: divisor[15:8] <= acc_wdata;
        default: ;
      endcase
    end
  end

  // Read data is captured when the access starts and held for the host
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (acc_rd) begin
      unique case (acc_addr) // RULE1
        `REG_DATA: rd_data <= rx_out_data;
        `REG_IER: rd_data <= {6'h00, ier};
        `REG_ISR: rd_data <= (ier[`IER_RX] && !rx_empty) ? `ISR_RX :
                             (ier[`IER_TX] && tx_empty) ? `ISR_TX : `ISR_NONE;
        `REG_LCR: rd_data <= lcr;
        `REG_MCR: rd_data <= modem_ctrl_reg;
        `REG_LSR: rd_data <= {1'b0, tx_empty && tx_state == TX_IDLE, tx_empty, 3'h0,
                              overrun, !rx_empty};
        `REG_DIV_LO: rd_data <= divisor[7:0];
        `REG_DIV_HI: rd_data <= divisor[15:8];
      endcase
    end
  end

  // Overrun is sticky; a new overrun beats the clearing status read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun <= 1'b0;
    end else if (rx_push && !rx_in_ready) begin
      overrun <= 1'b1;
    end else if (acc_rd && acc_addr == `REG_LSR) begin
      overrun <= 1'b0;
    end
  end

  // Bus drives only during an open read with chip select low
  assign host_data_bus_out = rd_data; // RULE3
  assign host_data_bus_oe_n = !(!serial_host_mode && !host_ctrl.cs_n && // RULE8
    (bus_style ? !host_ctrl.rd_n : host_ctrl.wr_n)); // RULE4 RULE6
  assign cpu_rdata = rd_data;

  // Interrupt pin shape depends on the bus style
  assign irq = (ier[`IER_RX] && !rx_empty) || (ier[`IER_TX] && tx_empty);
  assign int_out = bus_style && irq; // RULE10
  assign int_oe_n = bus_style ? !modem_ctrl_reg[`MCR_INT_EN] : !irq; // RULE9 RULE10
  assign tx_space_ready_n = tx_full; // RULE11
  assign rx_data_ready_n = rx_empty; // RULE12

  ////////////////////////////////////////////////////////////////////////
  // Byte buffers
  logic tx_in_ready_w, rx_out_valid_w;
  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo ( // RULE17
    .clk(clk), .reset_n(reset_n),
    .in_valid(acc_wr && acc_addr == `REG_DATA), .in_ready(tx_in_ready_w), .in_data(acc_wdata),
    .out_valid(tx_out_valid), .out_ready(tx_out_ready), .out_data(tx_out_data)
  );
  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo ( // RULE17
    .clk(clk), .reset_n(reset_n),
    .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rx_shift),
    .out_valid(rx_out_valid_w), .out_ready(acc_rd && acc_addr == `REG_DATA),
    .out_data(rx_out_data)
  );
  // Status flags come straight from the buffer handshakes; a write into a full buffer is lost
  assign tx_full = !tx_in_ready_w; // RULE11
  assign tx_empty = !tx_out_valid;
  assign rx_empty = !rx_out_valid_w; // RULE12

  ////////////////////////////////////////////////////////////////////////
  // Baud tick: divisor clamped to the range allowed in each host mode
  always_comb begin
    eff_div = divisor;
    if (serial_host_mode && divisor < 16'(SER_MIN_DIV)) eff_div = 16'(SER_MIN_DIV); // RULE16
    if (!serial_host_mode && divisor < 16'(PAR_MIN_DIV)) eff_div = 16'(PAR_MIN_DIV); // RULE15
    if (divisor > 16'(MAX_DIV)) eff_div = 16'(MAX_DIV); // RULE15 RULE16
  end
  assign tick = (baud_cnt >= eff_div - 16'h0001);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) baud_cnt <= 16'h0000;
    else baud_cnt <= tick ? 16'h0000 : baud_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: start, eight data bits LSB first, one stop bit
  assign tx_out_ready = (tx_state == TX_IDLE);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= TX_IDLE;
      tx_line <= 1'b1;
      tx_cnt <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1; // RULE13
          if (tx_out_valid) begin
            tx_shift <= tx_out_data;
            tx_state <= TX_START;
            tx_cnt <= 4'h0;
          end
        end
        TX_START, TX_DATA, TX_STOP: begin
          tx_line <= (tx_state == TX_START) ? 1'b0 : (tx_state == TX_STOP) ? 1'b1 : tx_shift[0];
          if (tick) begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == OS_LAST) begin
              if (tx_state == TX_START) tx_state <= TX_DATA;
              else if (tx_state == TX_STOP) tx_state <= TX_IDLE;
              else begin
                tx_shift <= {1'b0, tx_shift[7:1]};
                tx_bit <= tx_bit + 3'h1;
                if (tx_bit == 3'h7) tx_state <= TX_STOP;
              end
            end
          end
        end
      endcase
    end
  end
  // Alternate interface keeps the pin idle and loops data back inside
  assign tx_pin = modem_ctrl_reg[`MCR_ALT_IF] ? 1'b1 : tx_line; // RULE13

  ////////////////////////////////////////////////////////////////////////
  // Receiver: line idles high, start confirmed at mid bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end
  assign rx_src = modem_ctrl_reg[`MCR_ALT_IF] ? tx_line : rx_sync; // RULE14

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      unique case (rx_state)
        RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (!rx_src) rx_state <= RX_START; // RULE14
        end
        RX_START: if (tick) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == `RX_MID) begin
            rx_cnt <= 4'h0;
            rx_state <= rx_src ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (tick) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == OS_LAST) begin
            rx_shift <= {rx_src, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) rx_state <= RX_STOP;
          end
        end
        RX_STOP: if (tick) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == OS_LAST) begin
            rx_push <= rx_src;
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_cs_high_float: assert property (host_ctrl.cs_n |-> host_data_bus_oe_n) // RULE8
    else $error("data bus driven with chip select high");
  a_strobe_read_drive: assert property (!serial_host_mode && bus_style && // RULE4
    !host_ctrl.cs_n && !host_ctrl.rd_n |-> !host_data_bus_oe_n)
    else $error("read strobe did not drive the bus");
  a_strobe_write_store: assert property (par_wr && bus_style && acc_addr == `REG_MCR // RULE5
    |=> modem_ctrl_reg == $past(wr_hold))
    else $error("write strobe did not store the byte");
  a_dir_read_drive: assert property (!serial_host_mode && !bus_style && // RULE6
    !host_ctrl.cs_n && host_ctrl.wr_n |-> !host_data_bus_oe_n ##0 par_wr == 1'b0)
    else $error("direction read not driven");
  a_cpu_lockout: assert property (!serial_host_mode |-> !cpu_grant) // RULE2
    else $error("processor reached registers in parallel mode");
  a_int_float: assert property (bus_style && !modem_ctrl_reg[`MCR_INT_EN] |-> int_oe_n) // RULE9
    else $error("interrupt driven before enable");
  a_int_open_drain: assert property (!bus_style |-> !int_out && (int_oe_n == !irq)) // RULE10
    else $error("open drain interrupt drove high");
  a_ready_flags: assert property ((rx_push && rx_in_ready |=> !rx_data_ready_n) and // RULE11 RULE12
    (acc_wr && acc_addr == `REG_DATA && !tx_space_ready_n && !tx_out_valid |=> tx_out_valid))
    else $error("ready outputs disagree with buffers");
  a_tx_full_drop: assert property (acc_wr && acc_addr == `REG_DATA && tx_full && // RULE11 RULE17
    !tx_out_ready |=> tx_space_ready_n)
    else $error("write into a full transmit buffer was taken");
  a_tx_idle_high: assert property (tx_state == TX_IDLE ##1 tx_state == TX_IDLE |-> tx_pin) // RULE13
    else $error("transmit pin low while idle");
  a_rate_clamp: assert property (eff_div >= 16'(SER_MIN_DIV) && eff_div <= 16'(MAX_DIV) && // RULE15 RULE16
    (serial_host_mode || eff_div >= 16'(PAR_MIN_DIV)))
    else $error("baud divisor out of range");

  c_strobe_read: cover property (par_rd && bus_style);
  c_dir_write: cover property (par_wr && !bus_style);
  c_rx_byte: cover property (rx_push && rx_in_ready);
  c_tx_frame: cover property (tx_state == TX_STOP ##1 tx_state == TX_IDLE);
endmodule // uart_parallel_host_port

// ### test/serial_far_end.sv
// Remote serial station: sends frames to the device and decodes its transmit line
`timescale 1ns/1ps
module serial_far_end (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic from_dev,
  output logic to_dev,
  // Decoded frames
  output logic [7:0] got_byte,
  output logic got_stb,
  output logic got_bad
);
  // Bit period in clocks; the bench retunes it per rate
  int bit_cyc = 176;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels
  initial begin
    to_dev = 1'b1;
    got_byte = 8'h00;
    got_stb = 1'b0;
    got_bad = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sender, LSB first; line returns high so the next start edge is clean
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    to_dev = 1'b0;
    repeat (bit_cyc) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      to_dev = b[i];
      repeat (bit_cyc) @(negedge clk);
    end
    to_dev = 1'b1;
    repeat (bit_cyc) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver samples mid-bit, so small phase slips between the two ends do not matter
  initial forever begin
    @(negedge from_dev);
    repeat (bit_cyc / 2) @(posedge clk);
    got_bad = (from_dev !== 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      got_byte[i] = from_dev;
    end
    repeat (bit_cyc) @(posedge clk);
    got_bad = got_bad | (from_dev !== 1'b1);
    got_stb = 1'b1;
    @(posedge clk);
    got_stb = 1'b0;
  end
endmodule // serial_far_end

// ### test/uart_parallel_host_port_tb_top.sv
// Bench for the parallel host port: host driver, read and serial monitors
`timescale 1ns/1ps
module uart_parallel_host_port_tb_top;
  import uart_host_pkg::*;
  localparam int DEPTH = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  host_ctrl_t host_ctrl = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0};
  cpu_req_t cpu_req = '0;
  logic bus_style = 1'b1;
  logic serial_host_mode = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out, cpu_rdata, got_byte, rd_val;
  logic oe_n, cpu_grant, int_out, int_oe_n, tx_rdy_n, rx_rdy_n, tx_pin, rx_pin;
  logic got_stb, got_bad;
  logic [7:0] rq[$];
  logic [7:0] txq[$];
  event rd_ev;
  int num_errors = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial forever #12.5 clk = ~clk;

  uart_parallel_host_port #(.DEPTH(DEPTH)) u_dut (
    .clk(clk), .reset_n(reset_n), .host_ctrl(host_ctrl), .bus_style(bus_style),
    .host_data_bus_in(data_in), .host_data_bus_out(data_out), .host_data_bus_oe_n(oe_n),
    .serial_host_mode(serial_host_mode), .cpu_req(cpu_req), .cpu_grant(cpu_grant),
    .cpu_rdata(cpu_rdata), .int_out(int_out), .int_oe_n(int_oe_n),
    .tx_space_ready_n(tx_rdy_n), .rx_data_ready_n(rx_rdy_n), .tx_pin(tx_pin), .rx_pin(rx_pin));

  serial_far_end u_far (.clk(clk), .from_dev(tx_pin), .to_dev(rx_pin),
    .got_byte(got_byte), .got_stb(got_stb), .got_bad(got_bad));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic finish_test();
    $display("Errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Host write; the bus must still be floated two cycles into the write phase
  task automatic host_write(logic [2:0] a, logic [7:0] d);
    cyc(1);
    host_ctrl.addr = a;
    data_in = d;
    host_ctrl.cs_n = 1'b0;
    host_ctrl.wr_n = 1'b0;
    cyc(2);
    check("enable on write", 8'h01, {7'h0, oe_n});
    if (bus_style) begin
      host_ctrl.wr_n = 1'b1;
      cyc(1);
      host_ctrl.cs_n = 1'b1;
    end else begin
      host_ctrl.cs_n = 1'b1;
      cyc(1);
      host_ctrl.wr_n = 1'b1;
    end
    cyc(1);
  endtask

  // Host read; the expected byte goes to the queue and the monitor compares
  task automatic host_read(logic [2:0] a, logic [7:0] exp);
    cyc(1);
    host_ctrl.addr = a;
    host_ctrl.cs_n = 1'b0;
    if (bus_style) host_ctrl.rd_n = 1'b0;
    cyc(3);
    check("enable on read", 8'h00, {7'h0, oe_n});
    rq.push_back(exp);
    rd_val = data_out;
    ->rd_ev;
    host_ctrl.cs_n = 1'b1;
    if (bus_style) host_ctrl.rd_n = 1'b1;
    cyc(2);
  endtask

  task automatic cpu_op(logic wr, logic [2:0] a, logic [7:0] d);
    cyc(1);
    cpu_req = '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    cyc(1);
    check("processor grant", 8'h01, {7'h0, cpu_grant});
    cpu_req.sel = 1'b0;
    cyc(1);
  endtask

  // Bounded wait for every queued byte to come out of the transmit line
  task automatic drain_tx();
    int n;
    n = 0;
    while (txq.size() != 0 && n < 40000) begin
      cyc(1);
      n++;
    end
    if (txq.size() != 0) begin
      check("transmit drain", 8'h00, 8'hff);
      finish_test();
    end else begin
      cyc(40);
      check("line idle", 8'h01, {7'h0, tx_pin});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitors take the oldest note whenever a result appears
  always @(rd_ev) begin
    if (rq.size() == 0) check("read queue", 8'h00, 8'hff);
    else check("read data", rq.pop_front(), rd_val);
  end

  always @(posedge got_stb) begin
    check("frame bits", 8'h00, {7'h0, got_bad});
    if (txq.size() == 0) check("serial queue", 8'h00, 8'hff);
    else check("serial byte", txq.pop_front(), got_byte);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] rxv[3];
    int n;
    void'($urandom(32'h921a));
    cyc(12);
    check("reset status", 8'h1d, {3'h0, oe_n, int_oe_n, tx_pin, tx_rdy_n, rx_rdy_n});
    reset_n = 1'b1;
    host_read(3'h6, 8'h23);
    host_read(3'h7, 8'h08);
    host_read(3'h2, 8'h01);
    host_read(3'h5, 8'h60);
    v = 8'($urandom);
    host_write(3'h3, v);
    host_read(3'h3, v);
    // Strobes while deselected must neither store nor drive
    host_ctrl.rd_n = 1'b0;
    host_ctrl.wr_n = 1'b0;
    data_in = ~v;
    cyc(3);
    check("deselected enable", 8'h01, {7'h0, oe_n});
    host_ctrl.rd_n = 1'b1;
    host_ctrl.wr_n = 1'b1;
    host_read(3'h3, v);
    // Direction style with the read strobe held active to show it is ignored
    bus_style = 1'b0;
    host_ctrl.rd_n = 1'b0;
    v = 8'($urandom);
    host_write(3'h3, v);
    host_read(3'h3, v);
    bus_style = 1'b1;
    host_ctrl.rd_n = 1'b1;
    // Interrupt pin in both styles, transmit-empty source
    host_write(3'h1, 8'h02);
    check("int before enable", 8'h01, {7'h0, int_oe_n});
    host_write(3'h4, 8'h08);
    check("int strobe style", 8'h01, {6'h0, int_oe_n, int_out});
    bus_style = 1'b0;
    cyc(2);
    check("int direction style", 8'h00, {6'h0, int_oe_n, int_out});
    host_write(3'h1, 8'h00);
    check("int released", 8'h02, {6'h0, int_oe_n, int_out});
    bus_style = 1'b1;
    host_write(3'h4, 8'h00);
    // Fastest parallel rate, then fill the transmit buffer until it refuses
    host_write(3'h6, 8'h01);
    host_write(3'h7, 8'h00);
    n = 0;
    while (tx_rdy_n === 1'b0 && n < DEPTH + 2) begin
      v = 8'($urandom);
      txq.push_back(v);
      host_write(3'h0, v);
      n++;
    end
    check("transmit full", 8'h01, {7'h0, tx_rdy_n});
    host_write(3'h0, 8'hff); // Dropped while full
    drain_tx();
    check("transmit space", 8'h00, {7'h0, tx_rdy_n});
    // Receive path
    for (int i = 0; i < 3; i++) begin
      rxv[i] = 8'($urandom);
      u_far.send_byte(rxv[i]);
    end
    cyc(200);
    check("receive ready", 8'h00, {7'h0, rx_rdy_n});
    for (int i = 0; i < 3; i++) host_read(3'h0, rxv[i]);
    check("receive empty", 8'h01, {7'h0, rx_rdy_n});
    // Serial host mode: processor owns the registers, host is locked out
    serial_host_mode = 1'b1;
    v = 8'($urandom);
    cpu_op(1'b1, 3'h3, v);
    host_write(3'h3, ~v);
    cpu_op(1'b0, 3'h3, 8'h00);
    check("processor read", v, cpu_rdata);
    cpu_op(1'b1, 3'h6, 8'h01);
    cpu_op(1'b1, 3'h7, 8'h00);
    u_far.bit_cyc = 48;
    txq.push_back(8'ha5);
    cpu_op(1'b1, 3'h0, 8'ha5);
    drain_tx();
    serial_host_mode = 1'b0;
    host_read(3'h3, v);
    // Internal loopback: the pin stays idle while the byte returns to the receive buffer
    host_write(3'h4, 8'h40);
    v = 8'($urandom);
    host_write(3'h0, v);
    n = 0;
    repeat (2000) begin
      cyc(1);
      if (tx_pin !== 1'b1) n++;
    end
    check("loopback pin", 8'h00, {7'h0, n != 0});
    check("loopback ready", 8'h00, {7'h0, rx_rdy_n});
    host_read(3'h0, v);
    host_write(3'h4, 8'h00);
    finish_test();
  end
endmodule // uart_parallel_host_port_tb_top
